// *** hw/dfe_pkg.sv ***
// Shared constants and types of the failover and event unit
package dfe_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] FO_TRIG_OFS = 8'h00;
  localparam logic [7:0] FO_STAT_OFS = 8'h04;
  localparam logic [7:0] WD_LOAD_OFS = 8'h08;
  localparam logic [7:0] WD_COUNT_OFS = 8'h0C;
  localparam logic [7:0] EVT_STAT_OFS = 8'h10;
  localparam logic [7:0] EVT_EN0_OFS = 8'h14;
  localparam logic [7:0] EVT_EN1_OFS = 8'h18;
  localparam logic [7:0] MSG_DATA_OFS = 8'h1C;
  localparam logic [7:0] MSG_SEND_OFS = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EV_LINK = 0;
  localparam int EV_AER = 1;
  localparam int EV_RST = 2;
  localparam int EV_FO_INIT = 3;
  localparam int EV_FO_DONE = 4;
  localparam int EV_MSG0 = 5;
  localparam int EV_MSG1 = 6;
  localparam int EV_W = 7;
  localparam int ST_ROOT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_CAUSE_LSB = 2;
  localparam int ST_SRC_LSB = 4;
  localparam int MSG_TO_PRI = 0;
  localparam int MSG_TO_SEC = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [EV_W-1:0] EVT_EN_RST = 7'h00;
  localparam logic [EV_W-1:0] EVT_STAT_RST = 7'h00;
  localparam logic ROOT_RST = 1'b0;
  localparam logic [31:0] MSG_DATA_RST = 32'h0000_0000;
  localparam logic [31:0] WD_COUNT_RST = 32'h0000_0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WD_TICK_NS = 1000;
  localparam int WD_TICK_CYC = (WD_TICK_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int FO_SWITCH_NS = 200;
  localparam int FO_SWITCH_CYC = (FO_SWITCH_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int PIN_SETTLE = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CAUSE_NONE = 2'b00,
    CAUSE_SW = 2'b01,
    CAUSE_PIN = 2'b10,
    CAUSE_WD = 2'b11
  } dfe_cause_t;

  typedef enum logic [1:0] {
    FO_IDLE = 2'b00,
    FO_SWITCH = 2'b01,
    FO_DONE = 2'b10
  } dfe_fo_state_t;

endpackage : dfe_pkg

// *** hw/dfe_watchdog.sv ***
// Reloadable watchdog counter with tick divider
`timescale 1ns/100ps
`default_nettype none
module dfe_watchdog #(
  parameter int TICK_CYC = dfe_pkg::WD_TICK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Software load
  input wire logic load,
  input wire logic [31:0] load_val,
  // Status
  output logic [31:0] count,
  output logic running,
  output logic expire
);

  // ****************************************
  // Tick divider and countdown
  // ****************************************
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic [31:0] next_count;
  logic next_running;
  logic next_expire;
  logic tick;

  generate
    if (TICK_CYC < 1 || TICK_CYC > 65536)
    begin : g_bad_tick
      $error("watchdog tick count out of range");
    end
  endgenerate

  assign tick = running && (tick_cnt == 16'h0000);

  always_comb
  begin
    next_tick_cnt = tick_cnt;
    next_count = count;
    next_running = running;
    next_expire = 1'b0;
    if (load)
    begin
      next_count = load_val;
      next_running = (load_val != 32'h0000_0000);
      next_tick_cnt = 16'(TICK_CYC - 1);
    end
    else if (running)
    begin
      if (tick)
      begin
        next_tick_cnt = 16'(TICK_CYC - 1);
        next_count = count - 32'h0000_0001;
        if (count == 32'h0000_0001)
        begin
          next_running = 1'b0;
          next_expire = 1'b1;
        end
      end
      else
      begin
        next_tick_cnt = tick_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt <= 16'h0000;
      count <= dfe_pkg::WD_COUNT_RST;
      running <= 1'b0;
      expire <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      count <= next_count;
      running <= next_running;
      expire <= next_expire;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_load_start;
    load && (load_val != 32'h0000_0000) |=>
      running && (count == $past(load_val));
  endproperty
  a_load_start: assert property (p_load_start)
    else $error("load did not start countdown");

  property p_decrement;
    tick && !load && (count > 32'h0000_0001) |=>
      count == $past(count) - 32'h0000_0001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("watchdog did not decrement on tick");

  property p_expire_once;
    expire |-> !running ##1 !expire;
  endproperty
  a_expire_once: assert property (p_expire_once)
    else $error("watchdog expired more than once");

endmodule : dfe_watchdog
`default_nettype wire

// *** hw/dfe_failover_event_unit.sv ***
// Failover controller and global event signalling with APB registers
`timescale 1ns/100ps
`default_nettype none
module dfe_failover_event_unit #(
  parameter int FO_SWITCH_CYC = dfe_pkg::FO_SWITCH_CYC,
  parameter int WD_TICK_CYC = dfe_pkg::WD_TICK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Requester of the current transfer
  input wire logic [1:0] req_src,
  // External failover pin
  input wire logic failover_pin,
  // Switch event pulses
  input wire logic link_evt,
  input wire logic aer_evt,
  input wire logic part_rst_evt,
  // Root and interrupts
  output logic root_sel,
  output logic fo_busy,
  output logic irq_primary,
  output logic irq_secondary
);

  localparam int W = dfe_pkg::EV_W;

  generate
    if (FO_SWITCH_CYC < 1 || FO_SWITCH_CYC > 256)
    begin : g_bad_switch
      $error("switch cycle count out of range");
    end
  endgenerate

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a <= dfe_pkg::MSG_SEND_OFS);
  endfunction : addr_ok

  // ****************************************
  // APB handshake
  // ****************************************
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [31:0] rd_mux;
  logic xfer_done;
  logic wr_en;
  logic [W-1:0] evt_stat;
  logic [W-1:0] evt_en0;
  logic [W-1:0] evt_en1;
  logic [31:0] msg_data;
  logic [31:0] wd_count;
  logic wd_running;
  logic wd_expire;
  logic [1:0] cause;
  logic [1:0] src;

  assign xfer_done = psel && penable && pready;
  assign wr_en = xfer_done && pwrite && !pslverr;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      dfe_pkg::FO_STAT_OFS: rd_mux = {26'h0, src, cause, fo_busy, root_sel};
      dfe_pkg::WD_LOAD_OFS: rd_mux = {31'h0, wd_running};
      dfe_pkg::WD_COUNT_OFS: rd_mux = wd_count;
      dfe_pkg::EVT_STAT_OFS: rd_mux = {25'h0, evt_stat};
      dfe_pkg::EVT_EN0_OFS: rd_mux = {25'h0, evt_en0};
      dfe_pkg::EVT_EN1_OFS: rd_mux = {25'h0, evt_en1};
      dfe_pkg::MSG_DATA_OFS: rd_mux = msg_data;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_pready = pready;
    next_pslverr = pslverr;
    next_prdata = prdata;
    if (psel && !penable)
    begin
      next_pready = 1'b1;
      next_pslverr = !addr_ok(paddr);
      next_prdata = pwrite ? 32'h0000_0000 : rd_mux;
    end
    else if (xfer_done)
    begin
      next_pready = 1'b0;
      next_pslverr = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ****************************************
  // Failover pin synchroniser
  // ****************************************
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic [1:0] settle;
  logic [1:0] next_settle;
  logic pin_edge;

  always_comb
  begin
    next_settle = settle;
    if (settle != 2'(dfe_pkg::PIN_SETTLE))
    begin
      next_settle = settle + 2'b01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      settle <= 2'b00;
    end
    else
    begin
      pin_s1 <= failover_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      settle <= next_settle;
    end
  end

  assign pin_edge = (settle == 2'(dfe_pkg::PIN_SETTLE))
    && (pin_s2 != pin_s3);

  // ****************************************
  // Watchdog
  // ****************************************
  logic wd_load;

  assign wd_load = wr_en && (paddr == dfe_pkg::WD_LOAD_OFS);

  dfe_watchdog #(
    .TICK_CYC(WD_TICK_CYC)
  ) u_watchdog (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(wd_load),
    .load_val(pwdata),
    .count(wd_count),
    .running(wd_running),
    .expire(wd_expire)
  );

  // ****************************************
  // Failover sequencer
  // ****************************************
  dfe_pkg::dfe_fo_state_t state;
  dfe_pkg::dfe_fo_state_t next_state;
  logic [7:0] sw_cnt;
  logic [7:0] next_sw_cnt;
  logic next_root;
  logic next_busy;
  logic [1:0] next_cause;
  logic [1:0] next_src;
  logic trig_sw;
  logic trig;

  assign trig_sw = wr_en && (paddr == dfe_pkg::FO_TRIG_OFS);
  assign trig = trig_sw || pin_edge || wd_expire;

  always_comb
  begin
    next_state = state;
    next_sw_cnt = sw_cnt;
    next_root = root_sel;
    next_cause = cause;
    next_src = src;
    case (state)
      dfe_pkg::FO_IDLE:
      begin
        if (trig)
        begin
          next_state = dfe_pkg::FO_SWITCH;
          next_sw_cnt = 8'(FO_SWITCH_CYC - 1);
          if (trig_sw)
          begin
            next_cause = dfe_pkg::CAUSE_SW;
            next_src = req_src;
          end
          else if (pin_edge)
          begin
            next_cause = dfe_pkg::CAUSE_PIN;
          end
          else
          begin
            next_cause = dfe_pkg::CAUSE_WD;
          end
        end
      end
      dfe_pkg::FO_SWITCH:
      begin
        if (sw_cnt == 8'h00)
        begin
          next_root = !root_sel;
          next_state = dfe_pkg::FO_DONE;
        end
        else
        begin
          next_sw_cnt = sw_cnt - 8'h01;
        end
      end
      dfe_pkg::FO_DONE: next_state = dfe_pkg::FO_IDLE;
      default: next_state = dfe_pkg::FO_IDLE;
    endcase
    next_busy = (next_state != dfe_pkg::FO_IDLE);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= dfe_pkg::FO_IDLE;
      sw_cnt <= 8'h00;
      root_sel <= dfe_pkg::ROOT_RST;
      fo_busy <= 1'b0;
      cause <= dfe_pkg::CAUSE_NONE;
      src <= 2'b00;
    end
    else
    begin
      state <= next_state;
      sw_cnt <= next_sw_cnt;
      root_sel <= next_root;
      fo_busy <= next_busy;
      cause <= next_cause;
      src <= next_src;
    end
  end

  // ****************************************
  // Events, enables and interrupts
  // ****************************************
  logic [W-1:0] ev_set;
  logic [W-1:0] w1c;
  logic [W-1:0] next_stat;
  logic [W-1:0] next_en0;
  logic [W-1:0] next_en1;
  logic [31:0] next_msg;
  logic next_irq0;
  logic next_irq1;
  logic msg_send;

  assign msg_send = wr_en && (paddr == dfe_pkg::MSG_SEND_OFS);

  always_comb
  begin
    ev_set = '0;
    ev_set[dfe_pkg::EV_LINK] = link_evt;
    ev_set[dfe_pkg::EV_AER] = aer_evt;
    ev_set[dfe_pkg::EV_RST] = part_rst_evt;
    ev_set[dfe_pkg::EV_FO_INIT] = trig && (state == dfe_pkg::FO_IDLE);
    ev_set[dfe_pkg::EV_FO_DONE] = (state == dfe_pkg::FO_DONE);
    ev_set[dfe_pkg::EV_MSG0] = msg_send && pwdata[dfe_pkg::MSG_TO_PRI];
    ev_set[dfe_pkg::EV_MSG1] = msg_send && pwdata[dfe_pkg::MSG_TO_SEC];
    w1c = '0;
    if (wr_en && (paddr == dfe_pkg::EVT_STAT_OFS))
    begin
      w1c = pwdata[W-1:0];
    end
    next_stat = (evt_stat & ~w1c) | ev_set;
    next_en0 = evt_en0;
    next_en1 = evt_en1;
    next_msg = msg_data;
    if (wr_en && (paddr == dfe_pkg::EVT_EN0_OFS))
    begin
      next_en0 = pwdata[W-1:0];
    end
    if (wr_en && (paddr == dfe_pkg::EVT_EN1_OFS))
    begin
      next_en1 = pwdata[W-1:0];
    end
    if (wr_en && (paddr == dfe_pkg::MSG_DATA_OFS))
    begin
      next_msg = pwdata;
    end
    next_irq0 = |(next_stat & next_en0);
    next_irq1 = |(next_stat & next_en1);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      evt_stat <= dfe_pkg::EVT_STAT_RST;
      evt_en0 <= dfe_pkg::EVT_EN_RST;
      evt_en1 <= dfe_pkg::EVT_EN_RST;
      msg_data <= dfe_pkg::MSG_DATA_RST;
      irq_primary <= 1'b0;
      irq_secondary <= 1'b0;
    end
    else
    begin
      evt_stat <= next_stat;
      evt_en0 <= next_en0;
      evt_en1 <= next_en1;
      msg_data <= next_msg;
      irq_primary <= next_irq0;
      irq_secondary <= next_irq1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_sw_start;
    trig_sw && state == dfe_pkg::FO_IDLE |=>
      state == dfe_pkg::FO_SWITCH && fo_busy;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("trigger write did not start failover");

  property p_src_kept;
    trig_sw && state == dfe_pkg::FO_IDLE |=> src == $past(req_src);
  endproperty
  a_src_kept: assert property (p_src_kept)
    else $error("requester of trigger not recorded");

  property p_pin_start;
    pin_edge && !trig_sw && state == dfe_pkg::FO_IDLE |=>
      state == dfe_pkg::FO_SWITCH && cause == dfe_pkg::CAUSE_PIN;
  endproperty
  a_pin_start: assert property (p_pin_start)
    else $error("pin change did not start failover");

  property p_wd_start;
    wd_expire && !trig_sw && !pin_edge && state == dfe_pkg::FO_IDLE |=>
      state == dfe_pkg::FO_SWITCH && cause == dfe_pkg::CAUSE_WD;
  endproperty
  a_wd_start: assert property (p_wd_start)
    else $error("watchdog expiry did not start failover");

  property p_root_move;
    state == dfe_pkg::FO_SWITCH && sw_cnt == 8'h00 |=>
      root_sel != $past(root_sel) ##1 evt_stat[dfe_pkg::EV_FO_DONE];
  endproperty
  a_root_move: assert property (p_root_move)
    else $error("root did not move before done event");

  property p_init_evt;
    trig && state == dfe_pkg::FO_IDLE |=> evt_stat[dfe_pkg::EV_FO_INIT];
  endproperty
  a_init_evt: assert property (p_init_evt)
    else $error("failover start event missing");

  property p_gate_sec;
    !(|(evt_stat & evt_en1)) |-> !irq_secondary;
  endproperty
  a_gate_sec: assert property (p_gate_sec)
    else $error("interrupt to host without enabled event");

  property p_irq_pri;
    |(evt_stat & evt_en0) |-> irq_primary;
  endproperty
  a_irq_pri: assert property (p_irq_pri)
    else $error("enabled event did not interrupt host");

  property p_msg;
    msg_send && pwdata[dfe_pkg::MSG_TO_SEC] |=>
      evt_stat[dfe_pkg::EV_MSG1] [*2];
  endproperty
  a_msg: assert property (p_msg)
    else $error("host message event lost");

endmodule : dfe_failover_event_unit
`default_nettype wire

// *** testbench/dfe_host_model.sv ***
// Host and linecard model issuing APB transfers
`timescale 1ns/100ps
`default_nettype none
module dfe_host_model (
  // Clock
  input wire logic sys_clk,
  // APB master side
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [1:0] req_src,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    req_src = 2'h0;
  end

  // One transfer from any requester
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [1:0] s,
    output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    req_src <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    paddr <= ~a;
  endtask : xfer

  // Active host reloads the watchdog
  task automatic kick(input logic [31:0] n);
    logic [31:0] q;
    logic e;
    xfer(1'b1, dfe_pkg::WD_LOAD_OFS, n, 2'h0, q, e);
  endtask : kick

  // Word then event toward other hosts
  task automatic send_msg(input logic [31:0] w, input logic [1:0] to);
    logic [31:0] q;
    logic e;
    xfer(1'b1, dfe_pkg::MSG_DATA_OFS, w, 2'h0, q, e);
    xfer(1'b1, dfe_pkg::MSG_SEND_OFS, {30'h0, to}, 2'h0, q, e);
  endtask : send_msg
endmodule : dfe_host_model
`default_nettype wire

// *** testbench/dfe_failover_event_unit_bench.sv ***
// Self-checking bench of the failover and event unit
`timescale 1ns/100ps
`default_nettype none
module dfe_failover_event_unit_bench;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q1, q2;
  logic [1:0] req_src;
  logic failover_pin, link_evt, aer_evt, part_rst_evt, e;
  logic root_sel, fo_busy, irq_primary, irq_secondary;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  dfe_failover_event_unit #(.FO_SWITCH_CYC(4), .WD_TICK_CYC(2)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_src(req_src), .failover_pin(failover_pin),
    .link_evt(link_evt), .aer_evt(aer_evt),
    .part_rst_evt(part_rst_evt), .root_sel(root_sel),
    .fo_busy(fo_busy), .irq_primary(irq_primary),
    .irq_secondary(irq_secondary));

  dfe_host_model host_u (
    .sys_clk(sys_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .req_src(req_src),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Checks and helpers
  // ****************************************
  task automatic finish_test;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] s = 2'h0);
    host_u.xfer(1'b1, a, d, s, q1, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] m = 32'hFFFF_FFFF);
    host_u.xfer(1'b0, a, 32'h0000_0000, 2'h0, q1, e);
    check_word(q1 & m, exp);
  endtask : rd

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wait_fo;
    int n;
    n = 0;
    while (fo_busy !== 1'b1 && n < 300)
    begin
      tick();
      n++;
    end
    while (fo_busy !== 1'b0 && n < 600)
    begin
      tick();
      n++;
    end
    repeat (2) tick();
  endtask : wait_fo

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    failover_pin = 1'b0;
    link_evt = 1'b0;
    aer_evt = 1'b0;
    part_rst_evt = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(dfe_pkg::FO_STAT_OFS, 32'h0000_0000);
    rd(dfe_pkg::EVT_EN0_OFS, 32'h0000_0000);
    rd(dfe_pkg::MSG_DATA_OFS, 32'h0000_0000);
    rd(dfe_pkg::WD_COUNT_OFS, 32'h0000_0000);
    check_bit(root_sel, 1'b0);
    host_u.xfer(1'b0, 8'h40, 32'h0000_0000, 2'h0, q1, e);
    check_bit(e, 1'b1);
    // Switch events to the primary only
    wr(dfe_pkg::EVT_EN0_OFS, 32'h0000_007F);
    @(posedge sys_clk);
    link_evt <= 1'b1;
    aer_evt <= 1'b1;
    part_rst_evt <= 1'b1;
    @(posedge sys_clk);
    link_evt <= 1'b0;
    aer_evt <= 1'b0;
    part_rst_evt <= 1'b0;
    tick();
    rd(dfe_pkg::EVT_STAT_OFS, 32'h0000_0007);
    check_bit(irq_primary, 1'b1);
    check_bit(irq_secondary, 1'b0);
    wr(dfe_pkg::EVT_STAT_OFS, 32'h0000_0007);
    tick();
    check_bit(irq_primary, 1'b0);
    wr(dfe_pkg::EVT_EN0_OFS, 32'h0000_0000);
    // Message word to both hosts, interrupt enabled on the secondary only
    wr(dfe_pkg::EVT_EN1_OFS, 32'h0000_0040);
    host_u.send_msg(32'hA5A5_1234, 2'h3);
    tick();
    check_bit(irq_secondary, 1'b1);
    check_bit(irq_primary, 1'b0);
    rd(dfe_pkg::MSG_DATA_OFS, 32'hA5A5_1234);
    rd(dfe_pkg::EVT_STAT_OFS, 32'h0000_0060);
    wr(dfe_pkg::EVT_STAT_OFS, 32'h0000_007F);
    wr(dfe_pkg::EVT_EN1_OFS, 32'h0000_0000);
    // Linecard trigger, second trigger lands while busy
    wr(dfe_pkg::FO_TRIG_OFS, 32'h0000_0001, 2'h2);
    wr(dfe_pkg::FO_TRIG_OFS, 32'h0000_0001, 2'h1);
    wait_fo();
    check_bit(root_sel, 1'b1);
    rd(dfe_pkg::FO_STAT_OFS, 32'h0000_0025);
    rd(dfe_pkg::EVT_STAT_OFS, 32'h0000_0018);
    wr(dfe_pkg::EVT_STAT_OFS, 32'h0000_007F);
    // Pin level change
    @(posedge sys_clk);
    failover_pin <= 1'b1;
    wait_fo();
    check_bit(root_sel, 1'b0);
    rd(dfe_pkg::FO_STAT_OFS, 32'h0000_0008, 32'h0000_000F);
    wr(dfe_pkg::EVT_STAT_OFS, 32'h0000_007F);
    // Watchdog load, countdown, reloads, expiry
    wr(dfe_pkg::WD_LOAD_OFS, 32'h0000_0014);
    rd(dfe_pkg::WD_LOAD_OFS, 32'h0000_0001, 32'h0000_0001);
    host_u.xfer(1'b0, dfe_pkg::WD_COUNT_OFS, 32'h0, 2'h0, q2, e);
    repeat (7) @(posedge sys_clk);
    host_u.xfer(1'b0, dfe_pkg::WD_COUNT_OFS, 32'h0, 2'h0, q1, e);
    check_word(q2 - q1, 32'h0000_0005);
    repeat (4)
    begin
      host_u.kick(32'h0000_0014);
      repeat (10) @(posedge sys_clk);
    end
    tick();
    check_bit(fo_busy, 1'b0);
    check_bit(root_sel, 1'b0);
    wait_fo();
    check_bit(root_sel, 1'b1);
    rd(dfe_pkg::FO_STAT_OFS, 32'h0000_000D, 32'h0000_000F);
    wr(dfe_pkg::EVT_STAT_OFS, 32'h0000_007F);
    repeat (60) @(posedge sys_clk);
    rd(dfe_pkg::EVT_STAT_OFS, 32'h0000_0000);
    check_bit(root_sel, 1'b1);
    finish_test();
  end
endmodule : dfe_failover_event_unit_bench
`default_nettype wire
